// file: logic/addr_decode_pkg.sv
package addr_decode_pkg;
  // Widths
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  // Page zero high byte
  localparam logic [7:0] PAGE0_HI = 8'h00;
  // Instruction lengths
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  // Special opcodes
  localparam logic [7:0] OP_HALT_OSC = 8'h8E;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [7:0] OP_CALL_REL = 8'hAD;
  localparam logic [7:0] OP_MULTIPLY = 8'h42;
  localparam logic [7:0] OP_BAD_IMM_STORE = 8'hA7;
  localparam logic [7:0] OP_BAD_IMM_JUMP = 8'hAC;
  // Low nibbles with special meaning
  localparam logic [3:0] LO_TEST_NZ = 4'hD;
  localparam logic [3:0] LO_JUMP = 4'hC;
  localparam logic [3:0] LO_CALL = 4'hD;
  localparam logic [3:0] LO_STORE_A = 4'h7;
  localparam logic [3:0] LO_STORE_X = 4'hF;
  // Reset values of outputs
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // Addressing modes
  typedef enum logic [3:0] {
    MODE_INHERENT, MODE_IMMEDIATE, MODE_DIRECT, MODE_EXTENDED,
    MODE_IX0, MODE_IX1, MODE_IX2, MODE_RELATIVE, MODE_BIT_BRANCH
  } addr_mode_e;

  // Instruction classes
  typedef enum logic [2:0] {
    CLS_REG_MEM, CLS_RMW, CLS_JUMP_BRANCH, CLS_BIT_MANIP,
    CLS_CONTROL, CLS_ILLEGAL
  } instr_class_e;

  // Instruction length for a mode
  function automatic logic [1:0] mode_length(input addr_mode_e m);
    unique case (m)
      MODE_INHERENT, MODE_IX0: mode_length = LEN_ONE;
      MODE_EXTENDED, MODE_IX2, MODE_BIT_BRANCH: mode_length = LEN_THREE;
      default: mode_length = LEN_TWO;
    endcase
  endfunction

  // Sign-extend a branch offset to address width
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction
endpackage

// file: logic/address_former.sv
`timescale 1ns/1ps
// Effective address and next-address arithmetic
module address_former (
  // Decoded mode
  input wire addr_decode_pkg::addr_mode_e mode_in,
  // Instruction bytes and state
  input wire logic [15:0] pc_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] byte1_in,
  input wire logic [7:0] byte2_in,
  // Results
  output logic [15:0] eff_addr_out,
  output logic [15:0] seq_pc_out,
  output logic [15:0] target_out
);
  import addr_decode_pkg::*;
  logic [8:0] ix1_sum;
  logic [7:0] offset;

  // Unsigned 9-bit sum for the short indexed form
  assign ix1_sum = {1'b0, index_in} + {1'b0, byte1_in};
  // Bit branches carry their offset in the third byte
  assign offset = (mode_in == MODE_BIT_BRANCH) ? byte2_in : byte1_in;
  // Address of the next instruction
  assign seq_pc_out = pc_in + {14'h0000, mode_length(mode_in)};
  // Branch destination from the next address
  assign target_out = seq_pc_out + sext8(offset);

  // Operand address per mode
  always_comb begin
    unique case (mode_in)
      MODE_DIRECT, MODE_BIT_BRANCH:
        eff_addr_out = {PAGE0_HI, byte1_in};
      MODE_EXTENDED: eff_addr_out = {byte1_in, byte2_in};
      MODE_IX0: eff_addr_out = {PAGE0_HI, index_in};
      MODE_IX1: eff_addr_out = {7'h00, ix1_sum};
      MODE_IX2: eff_addr_out = {byte1_in, byte2_in}
        + {8'h00, index_in};
      default: eff_addr_out = ADDR_RST;
    endcase
  end
endmodule

// file: logic/cpu_address_mode_decode.sv
`timescale 1ns/1ps
// Decode and effective-address stage of the CPU
module cpu_address_mode_decode (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Instruction presented for decode
  input wire logic decode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand1_in,
  input wire logic [7:0] operand2_in,
  input wire logic [15:0] pc_in,
  // CPU state
  input wire logic [7:0] index_in,
  input wire logic [7:0] tested_byte_in,
  input wire logic carry_in,
  input wire logic zero_in,
  input wire logic negative_in,
  input wire logic half_carry_in,
  input wire logic imask_in,
  // Interrupt request pin level
  input wire logic irq_pin_in,
  // Decode results
  output logic done_out,
  output addr_decode_pkg::addr_mode_e mode_out,
  output addr_decode_pkg::instr_class_e class_out,
  output logic [1:0] length_out,
  output logic [15:0] eff_addr_out,
  output logic mem_read_out,
  output logic mem_write_out,
  // Program flow
  output logic [15:0] pc_next_out,
  output logic branch_taken_out,
  // Carry update from bit tests
  output logic carry_load_out,
  output logic carry_value_out,
  // Low-power requests
  output logic halt_osc_out,
  output logic irq_wake_out,
  output logic stop_cpu_clock_out,
  output logic clear_imask_out
);
  import addr_decode_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Opcode classification and address arithmetic

  // Shared decode bundle
  decode_if dec ();

  // Combinational address results
  logic [15:0] ea_c;
  logic [15:0] seq_c;
  logic [15:0] tgt_c;

  // Classifier
  opcode_classify u_classify (
    .opcode_in(opcode_in),
    .dec(dec.producer)
  );

  // Address arithmetic
  address_former u_former (
    .mode_in(dec.mode),
    .pc_in(pc_in),
    .index_in(index_in),
    .byte1_in(operand1_in),
    .byte2_in(operand2_in),
    .eff_addr_out(ea_c),
    .seq_pc_out(seq_c),
    .target_out(tgt_c)
  );

  //////////////////////////////////////////////////////////////////////
  // Branch condition evaluation

  // Base condition before the inversion bit
  logic cond_base;
  // Branch condition met
  logic taken_c;
  // Selected bit of the tested byte
  logic tested_bit;

  // Condition of the short branches
  always_comb begin
    unique case (opcode_in[3:1])
      3'h0: cond_base = 1'b1;
      3'h1: cond_base = !(carry_in || zero_in);
      3'h2: cond_base = !carry_in;
      3'h3: cond_base = !zero_in;
      3'h4: cond_base = !half_carry_in;
      3'h5: cond_base = !negative_in;
      3'h6: cond_base = !imask_in;
      default: cond_base = !irq_pin_in;
    endcase
  end

  // Bit number chosen by the opcode
  assign tested_bit = tested_byte_in[dec.bit_sel];

  // Taken decision per branch family
  always_comb begin
    taken_c = 1'b0;
    if (dec.mode == MODE_BIT_BRANCH) begin
      taken_c = (tested_bit == dec.bit_pol);
    end else if (opcode_in == OP_CALL_REL) begin
      taken_c = 1'b1;
    end else if (dec.mode == MODE_RELATIVE) begin
      taken_c = cond_base ^ opcode_in[0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Result registers

  // Next values
  logic done_d;
  addr_mode_e mode_d;
  instr_class_e class_d;
  logic [1:0] len_d;
  logic [15:0] ea_d;
  logic rd_d;
  logic wr_d;
  logic [15:0] pcn_d;
  logic taken_d;
  logic cload_d;
  logic cval_d;
  logic halt_d;
  logic wake_d;
  logic cstop_d;
  logic clri_d;

  // Compute the decode outcome
  always_comb begin
    done_d = 1'b0;
    mode_d = mode_out;
    class_d = class_out;
    len_d = length_out;
    ea_d = eff_addr_out;
    rd_d = 1'b0;
    wr_d = 1'b0;
    pcn_d = pc_next_out;
    taken_d = 1'b0;
    cload_d = 1'b0;
    cval_d = carry_value_out;
    halt_d = 1'b0;
    wake_d = 1'b0;
    cstop_d = 1'b0;
    clri_d = 1'b0;
    if (decode_valid_in) begin
      done_d = 1'b1;
      mode_d = dec.mode;
      class_d = dec.iclass;
      len_d = mode_length(dec.mode);
      ea_d = ea_c;
      rd_d = dec.mem_rd;
      wr_d = dec.mem_wr;
      taken_d = taken_c;
      // Default flow is the next instruction
      pcn_d = taken_c ? tgt_c : seq_c;
      if (dec.is_jump) begin
        pcn_d = ea_c;
      end
      if (dec.mode == MODE_BIT_BRANCH) begin
        cload_d = 1'b1;
        cval_d = tested_bit;
      end
      // Halt oscillator and arm the pin for wake
      if (opcode_in == OP_HALT_OSC) begin
        halt_d = 1'b1;
        wake_d = 1'b1;
      end
      // Wait stops the clock with interrupts open
      if (opcode_in == OP_WAIT) begin
        cstop_d = 1'b1;
        clri_d = 1'b1;
      end
    end
  end

  // Register the outcome
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      done_out <= 1'b0;
      mode_out <= MODE_INHERENT;
      class_out <= CLS_CONTROL;
      length_out <= LEN_ONE;
      eff_addr_out <= ADDR_RST;
      mem_read_out <= 1'b0;
      mem_write_out <= 1'b0;
      pc_next_out <= ADDR_RST;
      branch_taken_out <= 1'b0;
      carry_load_out <= 1'b0;
      carry_value_out <= 1'b0;
      halt_osc_out <= 1'b0;
      irq_wake_out <= 1'b0;
      stop_cpu_clock_out <= 1'b0;
      clear_imask_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= done_d;
      mode_out <= mode_d;
      class_out <= class_d;
      length_out <= len_d;
      eff_addr_out <= ea_d;
      mem_read_out <= rd_d;
      mem_write_out <= wr_d;
      pc_next_out <= pcn_d;
      branch_taken_out <= taken_d;
      carry_load_out <= cload_d;
      carry_value_out <= cval_d;
      halt_osc_out <= halt_d;
      irq_wake_out <= wake_d;
      stop_cpu_clock_out <= cstop_d;
      clear_imask_out <= clri_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  // Decode accepted this edge
  logic acc;
  assign acc = decode_valid_in && ce_in;

  AST_INH_ONE_BYTE: assert property (@(posedge clock_in)
    disable iff (srst_in) done_out && mode_out == MODE_INHERENT
    |-> length_out == LEN_ONE && !mem_read_out && !mem_write_out)
    else $error("inherent op not one byte or touched memory");

  AST_IMM_NO_ADDR: assert property (@(posedge clock_in)
    disable iff (srst_in) done_out && mode_out == MODE_IMMEDIATE
    |-> length_out == LEN_TWO && !mem_read_out && !mem_write_out)
    else $error("immediate op wrong length or accessed memory");

  AST_DIRECT_PAGE0: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'hB
    |=> length_out == LEN_TWO
    && eff_addr_out == {8'h00, $past(operand1_in)})
    else $error("direct address not in page zero");

  AST_EXT_ADDR: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'hC
    |=> length_out == LEN_THREE && eff_addr_out
    == {$past(operand1_in), $past(operand2_in)})
    else $error("extended address wrong");

  AST_IX0_ADDR: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'hF
    |=> length_out == LEN_ONE
    && eff_addr_out == {8'h00, $past(index_in)})
    else $error("indexed no-offset address wrong");

  AST_IX1_SUM: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'hE
    |=> eff_addr_out[15:9] == 7'h00 && eff_addr_out[8:0]
    == {1'b0, $past(index_in)} + {1'b0, $past(operand1_in)})
    else $error("8-bit indexed sum wrong");

  AST_BITBR_CARRY: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'h0
    |=> carry_load_out && length_out == LEN_THREE
    && carry_value_out == $past(tested_byte_in[opcode_in[3:1]]))
    else $error("tested bit not copied to carry");

  AST_BITBR_BASE: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'h0
    |=> pc_next_out == $past(pc_in) + 16'h0003
    + (branch_taken_out ? {{8{$past(operand2_in[7])}},
    $past(operand2_in)} : 16'h0000))
    else $error("bit branch destination wrong");

  AST_TEST_NO_WRITE: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[3:0] == 4'hD
    && opcode_in[7:4] inside {4'h3, 4'h6, 4'h7} |=> mem_read_out
    && !mem_write_out)
    else $error("negative-zero test wrote back");

  // Second cycle may hold the pulse only if frozen or a new wait came
  AST_WAIT_MASK: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in == OP_WAIT
    |=> stop_cpu_clock_out && clear_imask_out ##1 (!stop_cpu_clock_out
    || !$past(ce_in) || $past(acc && opcode_in == OP_WAIT)))
    else $error("wait did not stop clock and clear mask");

  AST_IX2_ADDR: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'hD
    |=> length_out == LEN_THREE && eff_addr_out
    == {$past(operand1_in), $past(operand2_in)} + {8'h00, $past(index_in)})
    else $error("16-bit indexed address wrong");

  AST_REL_TARGET: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] == 4'h2
    |=> length_out == LEN_TWO && pc_next_out == $past(pc_in) + 16'h0002
    + (branch_taken_out ? {{8{$past(operand1_in[7])}},
    $past(operand1_in)} : 16'h0000))
    else $error("relative branch destination wrong");

  AST_IRQ_PIN_BRANCH: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:1] == 7'h17
    |=> branch_taken_out == ($past(irq_pin_in) == $past(opcode_in[0])))
    else $error("pin level branch decision wrong");

  AST_JUMP_FLOW: assert property (@(posedge clock_in)
    disable iff (srst_in) acc && opcode_in[7:4] >= 4'hB
    && opcode_in[3:0] == 4'hC
    |=> pc_next_out == eff_addr_out && !mem_read_out && !mem_write_out)
    else $error("jump touched memory or missed its address");

  AST_HALT_WAKE: assert property (@(posedge clock_in)
    disable iff (srst_in) halt_osc_out |-> irq_wake_out)
    else $error("halt without pin wake enable");

  COV_TAKEN_REL: cover property (@(posedge clock_in)
    disable iff (srst_in) done_out && mode_out == MODE_RELATIVE
    && branch_taken_out);
  COV_BITBR_FALL: cover property (@(posedge clock_in)
    disable iff (srst_in) done_out && mode_out == MODE_BIT_BRANCH
    && !branch_taken_out);
  COV_IX1_HIGH: cover property (@(posedge clock_in)
    disable iff (srst_in) done_out && mode_out == MODE_IX1
    && eff_addr_out[8]);
endmodule

// file: logic/decode_if.sv
`timescale 1ns/1ps
// Opcode decode results shared between classifier and top
interface decode_if;
  import addr_decode_pkg::*;
  addr_mode_e mode;
  instr_class_e iclass;
  logic [2:0] bit_sel;
  logic bit_pol;
  logic mem_rd;
  logic mem_wr;
  logic is_jump;
  modport producer(output mode, iclass, bit_sel, bit_pol, mem_rd,
    mem_wr, is_jump);
  modport consumer(input mode, iclass, bit_sel, bit_pol, mem_rd,
    mem_wr, is_jump);
endinterface

// file: logic/opcode_classify.sv
`timescale 1ns/1ps
// Combinational opcode classifier
module opcode_classify (
  // Opcode
  input wire logic [7:0] opcode_in,
  // Decode results
  decode_if.producer dec
);
  import addr_decode_pkg::*;
  logic [3:0] hi;
  logic [3:0] lo;
  logic mem_mode;
  assign hi = opcode_in[7:4];
  assign lo = opcode_in[3:0];

  // Mode and class from the opcode map
  always_comb begin
    dec.iclass = CLS_RMW;
    unique case (hi)
      4'h0: dec.mode = MODE_BIT_BRANCH;
      4'h1: dec.mode = MODE_DIRECT;
      4'h2: dec.mode = MODE_RELATIVE;
      4'h3, 4'hB: dec.mode = MODE_DIRECT;
      4'h4, 4'h5, 4'h8, 4'h9: dec.mode = MODE_INHERENT;
      4'h6, 4'hE: dec.mode = MODE_IX1;
      4'h7, 4'hF: dec.mode = MODE_IX0;
      4'hA: dec.mode = (opcode_in == OP_CALL_REL) ? MODE_RELATIVE
        : MODE_IMMEDIATE;
      4'hC: dec.mode = MODE_EXTENDED;
      default: dec.mode = MODE_IX2;
    endcase
    if (hi <= 4'h1) begin
      dec.iclass = CLS_BIT_MANIP;
    end else if (hi == 4'h2 || opcode_in == OP_CALL_REL) begin
      dec.iclass = CLS_JUMP_BRANCH;
    end else if (opcode_in == OP_MULTIPLY) begin
      dec.iclass = CLS_REG_MEM;
    end else if (hi == 4'h8 || hi == 4'h9) begin
      dec.iclass = CLS_CONTROL;
    end else if (opcode_in == OP_BAD_IMM_STORE ||
        opcode_in == OP_BAD_IMM_JUMP) begin
      dec.iclass = CLS_ILLEGAL;
    end else if (hi >= 4'hA) begin
      dec.iclass = (lo == LO_JUMP || lo == LO_CALL) ? CLS_JUMP_BRANCH
        : CLS_REG_MEM;
    end
  end

  // Bit number and polarity come from the opcode
  assign dec.bit_sel = opcode_in[3:1];
  assign dec.bit_pol = ~opcode_in[0];
  assign dec.is_jump = (hi >= 4'hB) && (lo == LO_JUMP || lo == LO_CALL);
  assign mem_mode = !(dec.mode inside {MODE_INHERENT, MODE_IMMEDIATE,
    MODE_RELATIVE});

  // Memory access kind per class
  always_comb begin
    dec.mem_rd = 1'b0;
    dec.mem_wr = 1'b0;
    if (mem_mode) begin
      unique case (dec.iclass)
        CLS_RMW: begin
          dec.mem_rd = 1'b1;
          dec.mem_wr = (lo != LO_TEST_NZ);
        end
        CLS_BIT_MANIP: begin
          dec.mem_rd = 1'b1;
          dec.mem_wr = (hi == 4'h1);
        end
        CLS_REG_MEM: begin
          dec.mem_wr = (lo == LO_STORE_A || lo == LO_STORE_X);
          dec.mem_rd = !dec.mem_wr;
        end
        default: begin
          dec.mem_rd = 1'b0;
        end
      endcase
    end
  end
endmodule

// file: verif/mem_model.sv
`timescale 1ns/1ps
// Page-zero memory that answers bit-branch operand reads
module mem_model (
  // Clock
  input wire logic clock_in,
  // Write port used by the bench to preload bytes
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // Read port addressed by the bench's first operand byte
  input wire logic [15:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  // Storage for the first 256 locations
  logic [7:0] mem_q [256];
  ////////////////////////////////////////////////////////////////////////
  // Writes land on the rising edge
  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end
  // Read is combinational; outside page zero the bus shows the inverted stored byte
  always_comb begin
    if (rd_addr_in[15:8] == 8'h00) begin
      rd_data_out = mem_q[rd_addr_in[7:0]];
    end else begin
      rd_data_out = ~mem_q[rd_addr_in[7:0]];
    end
  end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
// Compare one value and count it
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import addr_decode_pkg::*;
  // Stimulus
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic decode_valid_in = 1'b0;
  logic [7:0] opcode_in = 8'h9D;
  logic [7:0] operand1_in = 8'h00;
  logic [7:0] operand2_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0] index_in = 8'h00;
  logic [7:0] tested_byte_in;
  logic [4:0] ccr = 5'h00;
  logic irq_pin_in = 1'b1;
  logic mem_wr = 1'b0;
  logic [7:0] mem_wa = 8'h00;
  logic [7:0] mem_wd = 8'h00;
  // Observed results
  logic done_out, mem_read_out, mem_write_out, branch_taken_out;
  logic carry_load_out, carry_value_out, halt_osc_out, irq_wake_out;
  logic stop_cpu_clock_out, clear_imask_out;
  addr_mode_e mode_out;
  instr_class_e class_out;
  logic [1:0] length_out;
  logic [15:0] eff_addr_out, pc_next_out;
  int miscompares = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    forever #10 clock_in = ~clock_in;
  end
  cpu_address_mode_decode i_dut (.clock_in, .srst_in, .ce_in,
    .decode_valid_in, .opcode_in, .operand1_in, .operand2_in, .pc_in,
    .index_in, .tested_byte_in, .carry_in(ccr[0]), .zero_in(ccr[1]),
    .negative_in(ccr[2]), .half_carry_in(ccr[3]), .imask_in(ccr[4]),
    .irq_pin_in, .done_out, .mode_out, .class_out, .length_out,
    .eff_addr_out, .mem_read_out, .mem_write_out, .pc_next_out,
    .branch_taken_out, .carry_load_out, .carry_value_out, .halt_osc_out,
    .irq_wake_out, .stop_cpu_clock_out, .clear_imask_out);
  mem_model i_mem (.clock_in, .wr_en_in(mem_wr), .wr_addr_in(mem_wa),
    .wr_data_in(mem_wd), .rd_addr_in({8'h00, operand1_in}),
    .rd_data_out(tested_byte_in));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Present one instruction and wait for its one-cycle answer
  task automatic dec(input logic [7:0] op, o1, o2, input logic [15:0] pc);
    @(posedge clock_in);
    decode_valid_in <= 1'b1;
    opcode_in <= op;
    operand1_in <= o1;
    operand2_in <= o2;
    pc_in <= pc;
    @(posedge clock_in);
    decode_valid_in <= 1'b0;
    #1;
    `CHK("done", 1'b1, done_out)
  endtask
  // Mode, length and memory access of the last decode
  task automatic chk(input addr_mode_e m, input logic [1:0] n,
    input logic rd, wr);
    `CHK("mode", m, mode_out)
    `CHK("length", n, length_out)
    `CHK("mem_read", rd, mem_read_out)
    `CHK("mem_write", wr, mem_write_out)
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Operand address per mode
  task automatic t_modes();
    dec(8'hC6, 8'h12, 8'h34, 16'h0200);
    chk(MODE_EXTENDED, 2'h3, 1'b1, 1'b0);
    `CHK("eff", 16'h1234, eff_addr_out)
    `CHK("pc_next", 16'h0203, pc_next_out)
    dec(8'hA6, 8'h55, 8'h00, 16'h0200);
    chk(MODE_IMMEDIATE, 2'h2, 1'b0, 1'b0);
    dec(8'hB7, 8'h80, 8'h00, 16'h0200);
    chk(MODE_DIRECT, 2'h2, 1'b0, 1'b1);
    `CHK("eff", 16'h0080, eff_addr_out)
    index_in <= 8'hFF;
    dec(8'hF6, 8'h00, 8'h00, 16'h0200);
    chk(MODE_IX0, 2'h1, 1'b1, 1'b0);
    `CHK("eff", 16'h00FF, eff_addr_out)
    dec(8'hE6, 8'hFF, 8'h00, 16'h0200);
    chk(MODE_IX1, 2'h2, 1'b1, 1'b0);
    `CHK("eff", 16'h01FE, eff_addr_out)
    index_in <= 8'h02;
    dec(8'hD6, 8'hFF, 8'hFF, 16'h0200);
    chk(MODE_IX2, 2'h3, 1'b1, 1'b0);
    `CHK("eff", 16'h0001, eff_addr_out)
  endtask
  // Read-modify-write sequencing
  task automatic t_rmw();
    dec(8'h3C, 8'h40, 8'h00, 16'h0300);
    chk(MODE_DIRECT, 2'h2, 1'b1, 1'b1);
    `CHK("class", CLS_RMW, class_out)
    dec(8'h3D, 8'h40, 8'h00, 16'h0300);
    chk(MODE_DIRECT, 2'h2, 1'b1, 1'b0);
    dec(8'h4C, 8'h00, 8'h00, 16'h0300);
    chk(MODE_INHERENT, 2'h1, 1'b0, 1'b0);
  endtask
  // Relative branches, both outcomes and both reach limits
  task automatic t_branch();
    ccr <= 5'h02;
    dec(8'h27, 8'hFE, 8'h00, 16'h0100);
    chk(MODE_RELATIVE, 2'h2, 1'b0, 1'b0);
    `CHK("taken", 1'b1, branch_taken_out)
    `CHK("pc_next", 16'h0100, pc_next_out)
    ccr <= 5'h00;
    dec(8'h27, 8'hFE, 8'h00, 16'h0100);
    `CHK("taken", 1'b0, branch_taken_out)
    `CHK("pc_next", 16'h0102, pc_next_out)
    dec(8'h20, 8'h7F, 8'h00, 16'h1000);
    `CHK("pc_next", 16'h1081, pc_next_out)
    dec(8'h20, 8'h80, 8'h00, 16'h1000);
    `CHK("pc_next", 16'h0F82, pc_next_out)
    `CHK("class", CLS_JUMP_BRANCH, class_out)
  endtask
  // Interrupt pin level branches
  task automatic t_irq();
    for (int p = 0; p < 2; p++) begin
      irq_pin_in <= p[0];
      dec(8'h2E, 8'h10, 8'h00, 16'h0400);
      `CHK("pin_low", ~p[0], branch_taken_out)
      dec(8'h2F, 8'h10, 8'h00, 16'h0400);
      `CHK("pin_high", p[0], branch_taken_out)
    end
  endtask
  // Bit test-and-branch over every bit and polarity
  task automatic t_bitbr();
    logic b;
    logic [15:0] tgt;
    logic [7:0] pat = 8'hA5;
    @(posedge clock_in);
    mem_wr <= 1'b1;
    mem_wa <= 8'h33;
    mem_wd <= 8'hA5;
    @(posedge clock_in);
    mem_wr <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      b = pat[n[3:1]] ^ n[0];
      tgt = b ? 16'h02F3 : 16'h0303;
      ccr <= {4'h0, ~pat[n[3:1]]};
      dec(n[7:0], 8'h33, 8'hF0, 16'h0300);
      chk(MODE_BIT_BRANCH, 2'h3, 1'b1, 1'b0);
      `CHK("eff", 16'h0033, eff_addr_out)
      `CHK("taken", b, branch_taken_out)
      `CHK("pc_next", tgt, pc_next_out)
      `CHK("c_load", 1'b1, carry_load_out)
      `CHK("c_val", pat[n[3:1]], carry_value_out)
    end
  endtask
  // Bit set and clear on page zero
  task automatic t_bitset();
    for (int n = 0; n < 16; n++) begin
      dec(8'h10 + n[7:0], 8'h33, 8'h00, 16'h0300);
      chk(MODE_DIRECT, 2'h2, 1'b1, 1'b1);
      `CHK("eff", 16'h0033, eff_addr_out)
      `CHK("class", CLS_BIT_MANIP, class_out)
    end
  endtask
  // Jumps redirect flow without touching memory
  task automatic t_jump();
    dec(8'hCC, 8'h12, 8'h34, 16'h0500);
    chk(MODE_EXTENDED, 2'h3, 1'b0, 1'b0);
    `CHK("pc_next", 16'h1234, pc_next_out)
    dec(8'hBD, 8'h44, 8'h00, 16'h0500);
    chk(MODE_DIRECT, 2'h2, 1'b0, 1'b0);
    `CHK("pc_next", 16'h0044, pc_next_out)
  endtask
  // Control group, with low-power side effects
  task automatic t_ctrl();
    logic [7:0] ops [13] = '{8'h80, 8'h81, 8'h83, 8'h97, 8'h98, 8'h99,
      8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9F, 8'h8E, 8'h8F};
    for (int i = 0; i < 13; i++) begin
      dec(ops[i], 8'h00, 8'h00, 16'h0600);
      chk(MODE_INHERENT, 2'h1, 1'b0, 1'b0);
      `CHK("class", CLS_CONTROL, class_out)
      `CHK("halt", ops[i] == 8'h8E, halt_osc_out)
      `CHK("wake", ops[i] == 8'h8E, irq_wake_out)
      `CHK("stopclk", ops[i] == 8'h8F, stop_cpu_clock_out)
      `CHK("clr_i", ops[i] == 8'h8F, clear_imask_out)
    end
  endtask
  // Odd opcodes, pulse drop, clock-enable freeze, mid-run reset
  task automatic t_misc();
    dec(8'hA7, 8'h00, 8'h00, 16'h0700);
    chk(MODE_IMMEDIATE, 2'h2, 1'b0, 1'b0);
    `CHK("class", CLS_ILLEGAL, class_out)
    dec(8'h42, 8'h00, 8'h00, 16'h0700);
    chk(MODE_INHERENT, 2'h1, 1'b0, 1'b0);
    `CHK("class", CLS_REG_MEM, class_out)
    dec(8'hAD, 8'h10, 8'h00, 16'h0700);
    chk(MODE_RELATIVE, 2'h2, 1'b0, 1'b0);
    `CHK("taken", 1'b1, branch_taken_out)
    `CHK("pc_next", 16'h0712, pc_next_out)
    // Idle edge: pulses drop, values hold; then present with enable low
    @(posedge clock_in);
    ce_in <= 1'b0;
    decode_valid_in <= 1'b1;
    opcode_in <= 8'hC6;
    #1;
    `CHK("done", 1'b0, done_out)
    `CHK("taken", 1'b0, branch_taken_out)
    `CHK("pc_next", 16'h0712, pc_next_out)
    @(posedge clock_in);
    ce_in <= 1'b1;
    decode_valid_in <= 1'b0;
    #1;
    `CHK("frozen_done", 1'b0, done_out)
    `CHK("frozen_mode", MODE_RELATIVE, mode_out)
    // One-edge reset in mid-run
    @(posedge clock_in);
    srst_in <= 1'b1;
    @(posedge clock_in);
    srst_in <= 1'b0;
    #1;
    `CHK("rst_pc", ADDR_RST, pc_next_out)
    `CHK("rst_mode", MODE_INHERENT, mode_out)
    `CHK("rst_len", LEN_ONE, length_out)
    // Index register still holds 02 from the mode scenario
    dec(8'hDC, 8'hAB, 8'hC0, 16'h0800);
    chk(MODE_IX2, 2'h3, 1'b0, 1'b0);
    `CHK("pc_next", 16'hABC2, pc_next_out)
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
    t_modes();
    t_rmw();
    t_branch();
    t_irq();
    t_bitbr();
    t_bitset();
    t_jump();
    t_ctrl();
    t_misc();
    end_of_test();
  end
  // Watchdog well beyond the roughly 150 cycles needed
  initial begin
    repeat (5000) @(posedge clock_in);
    miscompares++;
    end_of_test();
  end
endmodule
